// ### sdb_cfg.svh
// Offsets, field positions, reset values and timing counts of the bank 0 timing register bank.
`ifndef SDB_CFG_SVH
`define SDB_CFG_SVH

`define SDB_ADDR_W 8
`define SDB_OFS_ADT 8'h80
`define SDB_OFS_REV 8'h9C
`define SDB_OFS_AUX 8'hA0

`define SDB_RST_ADT 32'h00000000
`define SDB_RST_REV 32'h00000000
`define SDB_RST_AUX 32'h80805046

`define SDB_WMASK_ADT 32'hFFFFFFFF
`define SDB_WMASK_REV 32'h00030000
`define SDB_WMASK_AUX 32'hFFFFFFFF

`define SDB_POS_DATA_HOLD 24
`define SDB_POS_DATA_SETUP 16
`define SDB_POS_AC_HOLD 8
`define SDB_POS_AC_SETUP 0
`define SDB_POS_REV 16
`define SDB_POS_WR_REC 24
`define SDB_POS_MODE_REC 16
`define SDB_POS_SR_EXIT 8
`define SDB_POS_REFRESH 0

`define SDB_SIGN_BIT 7
`define SDB_TENTHS_PER_NS 8'h0A

`define SDB_CLK_PERIOD_NS 10
`define SDB_EIGHTHS_PER_NS 8
`define SDB_EIGHTHS_PER_CYCLE (`SDB_CLK_PERIOD_NS * `SDB_EIGHTHS_PER_NS)

`endif

// ### sdb_pkg.sv
// Types shared by the bank 0 timing register bank.
package sdb_pkg;

	typedef logic [7:0] sdb_byte_t;

	typedef struct packed {
		sdb_byte_t data_hold_time;
		sdb_byte_t data_setup_time;
		sdb_byte_t addr_cmd_hold_time;
		sdb_byte_t addr_cmd_setup_time;
	} sdb_setup_hold_s;

	typedef struct packed {
		logic signed [7:0] data_hold_tenths;
		logic signed [7:0] data_setup_tenths;
		logic signed [7:0] addr_cmd_hold_tenths;
		logic signed [7:0] addr_cmd_setup_tenths;
	} sdb_skew_s;

	typedef struct packed {
		sdb_byte_t write_recovery_time;
		sdb_byte_t mode_write_recovery_time;
		sdb_byte_t self_refresh_exit_latency;
		sdb_byte_t refresh_cycle_time;
	} sdb_aux_s;

	typedef struct packed {
		sdb_byte_t write_recovery_cycles;
		sdb_byte_t mode_write_recovery_cycles;
		sdb_byte_t self_refresh_exit_cycles;
		sdb_byte_t refresh_cycles;
	} sdb_cycles_s;

endpackage : sdb_pkg

// ### sdb_skew_decode.sv
// Decoder from a signed pseudo-BCD setup or hold byte to signed tenths of a nanosecond.
`timescale 1ns/1ps
`include "sdb_cfg.svh"

module sdb_skew_decode
(
	input wire logic [7:0] code,
	output logic signed [7:0] tenths,
	output logic bcd_ok
);
	logic [7:0] mag;

	// Whole nanoseconds in bits 6:4 and tenths in the low nibble; at most 85 tenths.
	assign mag = {5'h00, code[6:4]} * `SDB_TENTHS_PER_NS + {4'h0, code[3:0]};
	// Bit 7 set turns the magnitude negative.
	assign tenths = code[7] ? -$signed(mag) : $signed(mag);
	// A tenths digit above nine is not a valid code.
	assign bcd_ok = (code[3:0] <= 4'h9);

endmodule : sdb_skew_decode

// ### sdb_timing_regs.sv
// Bank 0 address/data timing, presence-detect revision and first auxiliary timing registers.
`timescale 1ns/1ps
`include "sdb_cfg.svh"

module sdb_timing_regs
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [`SDB_ADDR_W-1:0] cfg_addr,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output sdb_pkg::sdb_setup_hold_s setup_hold,
	output sdb_pkg::sdb_skew_s skew,
	output logic [3:0] skew_bcd_ok,
	output logic [1:0] presence_detect_revision,
	output sdb_pkg::sdb_aux_s aux_timing,
	output sdb_pkg::sdb_cycles_s aux_cycles
);
	import sdb_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Helper functions.

	// Merges a write into a register under byte enables and the writable mask.
	function automatic logic [31:0] sdb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] be, input logic [31:0] wmask);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
		sdb_merge = (old_v & ~m) | (new_v & m);
	endfunction : sdb_merge

	// Rounds a time up to whole clock cycles, since every figure here is a least time.
	function automatic logic [7:0] sdb_ceil_div(input logic [7:0] v, input logic [7:0] d);
		sdb_ceil_div = (v / d) + ((v % d) != 8'h00 ? 8'h01 : 8'h00);
	endfunction : sdb_ceil_div

	localparam logic [7:0] EIGHTHS_PER_CYCLE = 8'(`SDB_EIGHTHS_PER_CYCLE);
	localparam logic [7:0] NS_PER_CYCLE = 8'(`SDB_CLK_PERIOD_NS);

	////////////////////////////////////////////////////////////////////////////////
	// Register storage.

	logic [31:0] adt_q;
	logic [31:0] rev_q;
	logic [31:0] aux_q;
	logic [31:0] rdata_q;
	logic hit_adt;
	logic hit_rev;
	logic hit_aux;

	// Address decode; only the three aligned word offsets are mapped.
	assign hit_adt = (cfg_addr == `SDB_OFS_ADT);
	assign hit_rev = (cfg_addr == `SDB_OFS_REV);
	assign hit_aux = (cfg_addr == `SDB_OFS_AUX);

	// Address and data timing register, all four bytes writable.
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			adt_q <= `SDB_RST_ADT;
		else if (cfg_wr && hit_adt)
			adt_q <= sdb_merge(adt_q, cfg_wdata, cfg_be, `SDB_WMASK_ADT);
	end

	// Revision register keeps only bits 17:16 so the upper six bits of the byte stay zero.
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			rev_q <= `SDB_RST_REV;
		else if (cfg_wr && hit_rev)
			rev_q <= sdb_merge(rev_q, cfg_wdata, cfg_be, `SDB_WMASK_REV);
	end

	// First auxiliary timing register; the reset value suits 100 MHz modules.
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			aux_q <= `SDB_RST_AUX;
		else if (cfg_wr && hit_aux)
			aux_q <= sdb_merge(aux_q, cfg_wdata, cfg_be, `SDB_WMASK_AUX);
	end

	// Read data is captured one cycle after the read; unmapped offsets return zero.
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			rdata_q <= 32'h00000000;
		else if (cfg_rd)
		begin
			if (hit_adt)
				rdata_q <= adt_q;
			else if (hit_rev)
				rdata_q <= rev_q & `SDB_WMASK_REV;
			else if (hit_aux)
				rdata_q <= aux_q;
			else
				rdata_q <= 32'h00000000;
		end
	end

	assign cfg_rdata = rdata_q;

	////////////////////////////////////////////////////////////////////////////////
	// Values handed to the memory controller.

	logic signed [7:0] dec_tenths [4];
	logic [3:0] dec_ok;
	sdb_skew_s skew_q;
	logic [3:0] bcd_ok_q;
	sdb_cycles_s cycles_q;
	sdb_aux_s aux_v;

	// One decoder per setup or hold byte, byte 0 is the address/command setup time.
	for (genvar i = 0; i < 4; i++)
	begin : g_dec
		sdb_skew_decode u_dec
		(
			.code(adt_q[8*i +: 8]),
			.tenths(dec_tenths[i]),
			.bcd_ok(dec_ok[i])
		);
	end

	assign aux_v = sdb_aux_s'(aux_q);

	// Decoded signed skew values, one cycle behind the register.
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			skew_q <= '0;
			bcd_ok_q <= 4'hF;
		end
		else
		begin
			skew_q.data_hold_tenths <= dec_tenths[3];
			skew_q.data_setup_tenths <= dec_tenths[2];
			skew_q.addr_cmd_hold_tenths <= dec_tenths[1];
			skew_q.addr_cmd_setup_tenths <= dec_tenths[0];
			bcd_ok_q <= dec_ok;
		end
	end

	// Auxiliary times converted to whole clock cycles, rounded up.
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			cycles_q <= '0;
		else
		begin
			cycles_q.write_recovery_cycles <= sdb_ceil_div(aux_v.write_recovery_time, EIGHTHS_PER_CYCLE);
			cycles_q.mode_write_recovery_cycles <= sdb_ceil_div(aux_v.mode_write_recovery_time,
				EIGHTHS_PER_CYCLE);
			cycles_q.self_refresh_exit_cycles <= sdb_ceil_div(aux_v.self_refresh_exit_latency,
				NS_PER_CYCLE);
			cycles_q.refresh_cycles <= sdb_ceil_div(aux_v.refresh_cycle_time, NS_PER_CYCLE);
		end
	end

	assign setup_hold = sdb_setup_hold_s'(adt_q);
	assign skew = skew_q;
	assign skew_bcd_ok = bcd_ok_q;
	assign presence_detect_revision = rev_q[`SDB_POS_REV +: 2];
	assign aux_timing = aux_v;
	assign aux_cycles = cycles_q;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions.

	sequence s_full_write(logic hit);
		cfg_wr && hit && (cfg_be == 4'hF) && !cfg_rd;
	endsequence

	sequence s_read(logic hit);
		cfg_rd && hit && !cfg_wr;
	endsequence

	// The bus leaves one idle cycle between a write and the read that follows it.
	chk_adt_write_read: assert property (@(posedge core_clk) disable iff (!rst_b)
		s_full_write(hit_adt) ##1 !(cfg_wr && hit_adt) ##1 s_read(hit_adt) |=> cfg_rdata == $past(cfg_wdata, 3))
		else $error("Timing register read differs from the word written.");

	chk_aux_reset_val: assert property (@(posedge core_clk) disable iff (!rst_b)
		$rose(rst_b) && !cfg_wr |=> aux_q == `SDB_RST_AUX)
		else $error("Auxiliary register left reset with a wrong value.");

	chk_rev_reserved_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
		s_read(hit_rev) |=> cfg_rdata[31:18] == 14'h0000 && cfg_rdata[15:0] == 16'h0000)
		else $error("Revision register reserved bits read nonzero.");

	chk_rev_low_bits: assert property (@(posedge core_clk) disable iff (!rst_b)
		cfg_wr && hit_rev && cfg_be[2] |=> presence_detect_revision == $past(cfg_wdata[17:16]))
		else $error("Revision field did not take the written two bits.");

	chk_unmapped_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
		cfg_rd && !hit_adt && !hit_rev && !hit_aux |=> cfg_rdata == 32'h00000000)
		else $error("Unmapped offset read nonzero.");

	chk_aux_byte_lane: assert property (@(posedge core_clk) disable iff (!rst_b)
		cfg_wr && hit_aux && cfg_be == 4'h2 |=> aux_q[15:8] == $past(cfg_wdata[15:8])
		&& aux_q[31:16] == $past(aux_q[31:16]) && aux_q[7:0] == $past(aux_q[7:0]))
		else $error("Single byte write to auxiliary register touched other lanes.");

	chk_wr_rec_cycles: assert property (@(posedge core_clk) disable iff (!rst_b)
		$stable(aux_q) |=> aux_cycles.write_recovery_cycles == ($past(aux_q[31:24]) + 9'd79) / 9'd80)
		else $error("Write recovery cycle count wrong.");

	chk_refresh_cycles: assert property (@(posedge core_clk) disable iff (!rst_b)
		$stable(aux_q) |=> aux_cycles.refresh_cycles == ($past(aux_q[7:0]) + 9'd9) / 9'd10)
		else $error("Refresh cycle count wrong.");

	chk_skew_sign: assert property (@(posedge core_clk) disable iff (!rst_b)
		adt_q[7] && adt_q[6:0] != 7'h00 |=> skew.addr_cmd_setup_tenths < 0)
		else $error("Negative setup code did not decode negative.");

	chk_skew_magnitude: assert property (@(posedge core_clk) disable iff (!rst_b)
		!adt_q[31] |=> skew.data_hold_tenths == $past(adt_q[30:28]) * 10 + $past(adt_q[27:24]))
		else $error("Positive hold code decoded to a wrong magnitude.");

endmodule : sdb_timing_regs

// ### sdb_sw_model.sv
// Configuration software model that drives the register strobe bus.
`timescale 1ns/1ps
`include "sdb_cfg.svh"

module sdb_sw_model
(
	input wire logic core_clk,
	output logic [`SDB_ADDR_W-1:0] cfg_addr,
	output logic cfg_wr,
	output logic cfg_rd,
	output logic [3:0] cfg_be,
	output logic [31:0] cfg_wdata,
	input wire logic [31:0] cfg_rdata
);

	// Bus idles with no strobe raised.
	initial
	begin
		cfg_addr = 8'h00;
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
		cfg_be = 4'h0;
		cfg_wdata = 32'h00000000;
	end

	// One write pulse; released data turns to its inverse so stale values never pass.
	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		@(posedge core_clk);
		#1;
		cfg_addr = a;
		cfg_be = be;
		cfg_wdata = d;
		cfg_wr = 1'b1;
		@(posedge core_clk);
		#1;
		cfg_wr = 1'b0;
		cfg_wdata = ~d;
	endtask : wr

	// One read pulse; data is taken once the edge after the strobe has landed.
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		#1;
		cfg_addr = a;
		cfg_rd = 1'b1;
		@(posedge core_clk);
		#1;
		cfg_rd = 1'b0;
		d = cfg_rdata;
	endtask : rd

endmodule : sdb_sw_model

// ### tb_sdram_bank0_timing_param_regs.sv
// Self-checking testbench of the bank 0 timing register bank.
`timescale 1ns/1ps
`include "sdb_cfg.svh"

module tb_sdram_bank0_timing_param_regs;
	import sdb_pkg::*;

	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [`SDB_ADDR_W-1:0] cfg_addr;
	logic cfg_wr, cfg_rd;
	logic [3:0] cfg_be;
	logic [31:0] cfg_wdata, cfg_rdata, rv, d, seed;
	sdb_setup_hold_s setup_hold;
	sdb_skew_s skew;
	logic [3:0] skew_bcd_ok;
	logic [1:0] presence_detect_revision;
	sdb_aux_s aux_timing;
	sdb_cycles_s aux_cycles;
	logic [31:0] regs [3];
	logic [7:0] ofs [3] = '{`SDB_OFS_ADT, `SDB_OFS_REV, `SDB_OFS_AUX};
	logic [31:0] msk [3] = '{`SDB_WMASK_ADT, `SDB_WMASK_REV, `SDB_WMASK_AUX};
	logic [31:0] corner [4] = '{32'h80FF7F09, 32'hFFFFFFFF, 32'h00000000, 32'h51500A0B};
	int fails = 0;
	int n_tests = 0;

	sdb_timing_regs u_dut (.core_clk(core_clk), .rst_b(rst_b), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
		.cfg_rd(cfg_rd), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.setup_hold(setup_hold), .skew(skew), .skew_bcd_ok(skew_bcd_ok),
		.presence_detect_revision(presence_detect_revision), .aux_timing(aux_timing), .aux_cycles(aux_cycles));
	sdb_sw_model u_sw (.core_clk(core_clk), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
		.cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));

	////////////////////////////////////////////////////////////////////////////////
	// Free-running 100 MHz clock.
	always #5 core_clk = ~core_clk;

	// Galois shift register, advanced eight steps per value.
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		for (int i = 0; i < 8; i++)
			s = s[0] ? ((s >> 1) ^ 32'hA3000000) : (s >> 1);
		return s;
	endfunction : lfsr

	// Signed tenths of a nanosecond from a sign plus pseudo-BCD byte.
	function automatic logic [7:0] skew_exp(input logic [7:0] c);
		logic [7:0] m;
		m = c[6:4] * 8'h0A + c[3:0];
		return c[7] ? -m : m;
	endfunction : skew_exp

	// Division rounded up, since timings are minimum values.
	function automatic logic [7:0] cdiv(input logic [7:0] v, input logic [7:0] q);
		return 8'((16'(v) + 16'(q) - 16'h0001) / 16'(q));
	endfunction : cdiv

	// Compares one value and reports a mismatch at once.
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			fails++;
		end
	endtask : cmp

	// Prints the counts and the verdict, then ends the run.
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog against a hung bus.
	initial
	begin
		#200000;
		fails++;
		complete_run();
	end

	// Reset values, then corner and random writes with readback and decoded outputs.
	initial
	begin
		seed = 32'h00000056;
		regs = '{`SDB_RST_ADT, `SDB_RST_REV, `SDB_RST_AUX};
		repeat (12) @(posedge core_clk);
		cmp("aux in reset", 32'h80805046, aux_timing);
		cmp("setup_hold in reset", 32'h00000000, setup_hold);
		#1;
		rst_b = 1'b1;
		@(posedge core_clk);
		#1;
		// Sixteen nanoseconds over a ten nanosecond cycle round up to two cycles.
		cmp("aux_cycles after reset", 32'h02020807, aux_cycles);
		for (int k = 0; k < 3; k++)
		begin
			u_sw.rd(ofs[k], rv);
			cmp("reset readback", regs[k], rv);
		end
		$display("reset test done");
		for (int i = 0; i < 24; i++)
		begin
			for (int k = 0; k < 3; k++)
			begin
				seed = lfsr(seed);
				d = (i < 4) ? corner[i] : seed;
				cfg_be_sel(i, k);
			end
			seed = lfsr(seed);
			// Offsets 84h to 90h are never mapped, so the random write cannot land.
			u_sw.wr(8'h84 + {4'h0, seed[1:0], 2'b00}, 4'hF, seed);
			u_sw.rd(8'h84 + {4'h0, seed[1:0], 2'b00}, rv);
			cmp("unmapped read", 32'h00000000, rv);
			cmp("setup_hold", regs[0], setup_hold);
			cmp("revision", {30'h0, regs[1][17:16]}, {30'h0, presence_detect_revision});
			cmp("aux_timing", regs[2], aux_timing);
			for (int b = 0; b < 4; b++)
			begin
				cmp("skew", skew_exp(regs[0][8*b+:8]), skew[8*b+:8]);
				cmp("bcd_ok", regs[0][8*b+:4] <= 4'h9, skew_bcd_ok[b]);
				cmp("aux_cycles", cdiv(regs[2][8*b+:8], b > 1 ? 8'h50 : 8'h0A), aux_cycles[8*b+:8]);
			end
		end
		$display("register test done");
		// Reset again in mid-run; every register returns to its reset value.
		@(posedge core_clk);
		#1;
		rst_b = 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		cmp("aux in second reset", 32'h80805046, aux_timing);
		cmp("setup_hold in second reset", 32'h00000000, setup_hold);
		cmp("revision in second reset", 32'h00000000, {30'h0, presence_detect_revision});
		cmp("aux_cycles in second reset", 32'h00000000, aux_cycles);
		rst_b = 1'b1;
		regs = '{`SDB_RST_ADT, `SDB_RST_REV, `SDB_RST_AUX};
		@(posedge core_clk);
		#1;
		cmp("aux_cycles after second reset", 32'h02020807, aux_cycles);
		for (int k = 0; k < 3; k++)
		begin
			u_sw.rd(ofs[k], rv);
			cmp("second reset readback", regs[k], rv);
		end
		$display("second reset test done");
		complete_run();
	end

	// Writes one register with all four lanes for the corner values and random lanes after them, updates the expected copy and reads it back.
	task automatic cfg_be_sel(input int i, input int k);
		logic [31:0] bm;
		logic [3:0] be;
		be = (i < 4) ? 4'hF : seed[27:24];
		bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		u_sw.wr(ofs[k], be, d);
		regs[k] = (regs[k] & ~(bm & msk[k])) | (d & bm & msk[k]);
		u_sw.rd(ofs[k], rv);
		cmp("readback", regs[k], rv);
	endtask : cfg_be_sel

endmodule : tb_sdram_bank0_timing_param_regs
